// >>> rtl/smcmd_top.v
// Serial drive command slave: frames Modbus requests from received characters,
// checks them, executes reads and single writes and queues the response characters.
// Assumes a UART on the same clock delivers and takes whole characters.
`timescale 1ns/100ps
`default_nettype none
`include "smcmd_map.vh"

module smcmd_top
#(
    parameter [`SMC_GAP_W-1:0] SILENCE_CYC = `SMC_SILENCE_CYC
)
(
    input  wire        CLOCK,
    input  wire        RST_N,
    input  wire        ASCII_MODE,
    input  wire [7:0]  SLAVE_ADDR,
    input  wire        OPERATOR_PANEL_LIT,
    input  wire        RX_VALID,
    input  wire [7:0]  RX_CHAR,
    output reg         TX_VALID,
    output reg  [7:0]  TX_CHAR,
    input  wire        TX_READY,
    output reg  [15:0] FREQ_SETPOINT,
    output reg         RUN_CMD,
    output reg         REVERSE_CMD,
    output reg         EXTERNAL_FAULT_INPUT,
    output reg         FAULT_RESET,
    output reg  [3:0]  PARAM_GROUP,
    output reg  [6:0]  PARAM_INDEX,
    output reg  [15:0] PARAM_WDATA,
    output reg         PARAM_WE,
    input  wire [15:0] PARAM_RDATA
);
    localparam S_RX     = 2'h0;
    localparam S_EXEC   = 2'h1;
    localparam S_RDWAIT = 2'h2;
    localparam S_TX     = 2'h3;
    localparam T_SOF    = 2'h0;
    localparam T_DAT    = 2'h1;
    localparam T_CR     = 2'h2;
    localparam T_LF     = 2'h3;

    reg  [1:0]            st_q;
    reg  [1:0]            tst_q;
    reg                   panel_m_q;
    reg                   panel_s_q;
    reg  [`SMC_GAP_W-1:0] gap_q;
    reg  [7:0]            rb_q [0:7];
    reg  [7:0]            tb_q [0:5];
    reg  [3:0]            cnt_q;
    reg                   ovf_q;
    reg                   in_frame_q;
    reg                   nib_q;
    reg  [3:0]            hi_q;
    reg                   cr_q;
    reg  [2:0]            rlen_q;
    reg  [2:0]            pos_q;
    reg                   tnib_q;
    reg  [4:0]            hexin;
    reg                   rx_clr;
    reg                   rx_stb;
    reg  [7:0]            rx_byte;
    reg                   frame_done;
    reg  [7:0]            cur_byte;
    reg  [7:0]            tx_ch;
    wire [15:0]           rx_crc;
    wire [7:0]            rx_lrc;
    wire [15:0]           tx_crc;
    wire [7:0]            tx_lrc;
    wire                  fifo_in_ready;
    wire                  fifo_out_valid;
    wire [7:0]            fifo_out_data;
    wire                  fifo_pop_ok;
    wire                  push;
    wire                  tx_step;
    wire [15:0]           reg_addr;
    wire [15:0]           reg_val;
    wire                  addr_ok;
    wire                  chk_ok;
    wire                  len_ok;
    wire                  ctl_ok;
    wire [2:0]            last_pos;

    // Returns {valid, nibble} for an upper-case hex character
    function [4:0] hex_dec;
        input [7:0] c;
        begin
            if (c >= 8'h30 && c <= 8'h39)
                hex_dec = {1'b1, c[3:0]};
            else if (c >= 8'h41 && c <= 8'h46)
                hex_dec = {1'b1, c[3:0] + 4'h9};
            else
                hex_dec = 5'h00;
        end
    endfunction

    function [7:0] hex_enc;
        input [3:0] n;
        begin
            hex_enc = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
        end
    endfunction

    function [10:0] param_split;
        input [15:0] a;
        reg   [15:0] g;
        reg   [15:0] r;
        begin
            g = a / `SMC_GROUP_STRIDE;
            r = a - g * `SMC_GROUP_STRIDE;
            param_split = {g[3:0], r[6:0]};
        end
    endfunction

    assign reg_addr = {rb_q[2], rb_q[3]};
    assign reg_val  = {rb_q[4], rb_q[5]};
    assign addr_ok  = (rb_q[0] == `SMC_ADDR_BCAST_MUTE) || (rb_q[0] == `SMC_ADDR_BCAST_ECHO)
                    || (rb_q[0] == SLAVE_ADDR);
    assign chk_ok   = ASCII_MODE ? (rx_lrc == 8'h00) : (rx_crc == 16'h0000);
    assign len_ok   = !ovf_q && (cnt_q == (ASCII_MODE ? `SMC_LEN_ASCII : `SMC_LEN_RTU));
    assign ctl_ok   = reg_val[`SMC_CTL_OVR] || !panel_s_q;
    assign last_pos = rlen_q + (ASCII_MODE ? 3'h0 : 3'h1);
    assign push     = (st_q == S_TX) && fifo_in_ready;
    assign tx_step  = push && (tst_q == T_DAT) && !tnib_q && (pos_q < rlen_q);
    assign fifo_pop_ok = !TX_VALID || TX_READY;

    // Receive side: characters to bytes, frame start and end
    always @*
    begin
        hexin      = hex_dec(RX_CHAR);
        rx_clr     = 1'b0;
        rx_stb     = 1'b0;
        rx_byte    = RX_CHAR;
        frame_done = 1'b0;
        if (ASCII_MODE)
        begin
            rx_clr     = RX_VALID && (st_q == S_RX) && (RX_CHAR == `SMC_CH_COLON);
            rx_stb     = RX_VALID && (st_q == S_RX) && in_frame_q && nib_q && hexin[4];
            rx_byte    = {hi_q, hexin[3:0]};
            frame_done = RX_VALID && (st_q == S_RX) && in_frame_q && cr_q
                       && (RX_CHAR == `SMC_CH_LF);
        end
        else
        begin
            rx_stb     = RX_VALID && (st_q == S_RX);
            rx_clr     = rx_stb && (gap_q == SILENCE_CYC);
            frame_done = (st_q == S_RX) && (gap_q == SILENCE_CYC) && (cnt_q != 4'h0);
        end
    end

    // Transmit character for the current position
    always @*
    begin
        if (pos_q < rlen_q)
            cur_byte = tb_q[pos_q];
        else if (ASCII_MODE)
            cur_byte = tx_lrc;
        else if (pos_q == rlen_q)
            cur_byte = tx_crc[7:0];
        else
            cur_byte = tx_crc[15:8];
        case (tst_q)
            T_SOF: tx_ch = `SMC_CH_COLON;
            T_DAT: tx_ch = !ASCII_MODE ? cur_byte :
                           hex_enc(tnib_q ? cur_byte[3:0] : cur_byte[7:4]);
            T_CR:  tx_ch = `SMC_CH_CR;
            default: tx_ch = `SMC_CH_LF;
        endcase
    end

    smcmd_check u_rx_chk
    (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .clear (rx_clr),
        .step  (rx_stb),
        .data  (rx_byte),
        .crc   (rx_crc),
        .lrc   (rx_lrc)
    );

    smcmd_check u_tx_chk
    (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .clear (st_q == S_EXEC),
        .step  (tx_step),
        .data  (cur_byte),
        .crc   (tx_crc),
        .lrc   (tx_lrc)
    );

    smcmd_fifo #(.WIDTH(`SMC_FIFO_W), .DEPTH(`SMC_FIFO_D), .AW(3)) u_fifo
    (
        .clk       (CLOCK),
        .rst_n     (RST_N),
        .in_valid  (st_q == S_TX),
        .in_ready  (fifo_in_ready),
        .in_data   (tx_ch),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop_ok),
        .out_data  (fifo_out_data)
    );

    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            panel_m_q <= 1'b0;
            panel_s_q <= 1'b0;
            TX_VALID  <= 1'b0;
            TX_CHAR   <= 8'h00;
        end
        else
        begin
            panel_m_q <= OPERATOR_PANEL_LIT;
            panel_s_q <= panel_m_q;
            if (fifo_out_valid && fifo_pop_ok)
            begin
                TX_VALID <= 1'b1;
                TX_CHAR  <= fifo_out_data;
            end
            else if (TX_READY)
                TX_VALID <= 1'b0;
        end
    end

    always @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            st_q  <= S_RX;
            tst_q <= T_SOF;
            gap_q <= SILENCE_CYC;
            cnt_q <= 4'h0;
            ovf_q <= 1'b0;
            in_frame_q <= 1'b0;
            nib_q  <= 1'b0;
            hi_q   <= 4'h0;
            cr_q   <= 1'b0;
            rlen_q <= 3'h0;
            pos_q  <= 3'h0;
            tnib_q <= 1'b0;
            FREQ_SETPOINT <= 16'h0000;
            RUN_CMD     <= 1'b0;
            REVERSE_CMD <= 1'b0;
            EXTERNAL_FAULT_INPUT <= 1'b0;
            FAULT_RESET <= 1'b0;
            PARAM_GROUP <= 4'h0;
            PARAM_INDEX <= 7'h00;
            PARAM_WDATA <= 16'h0000;
            PARAM_WE    <= 1'b0;
        end
        else
        begin
            EXTERNAL_FAULT_INPUT <= 1'b0;
            FAULT_RESET <= 1'b0;
            PARAM_WE    <= 1'b0;
            if (RX_VALID)
                gap_q <= {`SMC_GAP_W{1'b0}};
            else if (gap_q != SILENCE_CYC)
                gap_q <= gap_q + 1'b1;
            case (st_q)
                S_RX:
                begin
                    if (rx_clr)
                    begin
                        cnt_q <= 4'h0;
                        ovf_q <= 1'b0;
                        in_frame_q <= 1'b1;
                        nib_q <= 1'b0;
                        cr_q  <= 1'b0;
                    end
                    if (ASCII_MODE && RX_VALID && !rx_clr)
                    begin
                        if (hexin[4] && !cr_q)
                        begin
                            nib_q <= !nib_q;
                            hi_q  <= hexin[3:0];
                        end
                        else if (RX_CHAR == `SMC_CH_CR && !nib_q)
                            cr_q <= 1'b1;
                        else
                            in_frame_q <= 1'b0;
                    end
                    if (rx_stb)
                    begin
                        if (cnt_q[3])
                            ovf_q <= 1'b1;
                        else
                            rb_q[cnt_q[2:0]] <= rx_byte;
                        if (!rx_clr)
                            cnt_q <= cnt_q + (cnt_q[3] ? 4'h0 : 4'h1);
                        else
                        begin
                            rb_q[0] <= rx_byte;
                            cnt_q <= 4'h1;
                        end
                    end
                    if (frame_done)
                    begin
                        in_frame_q <= 1'b0;
                        cnt_q <= 4'h0;
                        if (chk_ok && len_ok && addr_ok)
                            st_q <= S_EXEC;
                    end
                end
                S_EXEC:
                begin
                    st_q  <= S_RX;
                    tst_q <= ASCII_MODE ? T_SOF : T_DAT;
                    pos_q <= 3'h0;
                    tnib_q <= 1'b0;
                    tb_q[0] <= rb_q[0];
                    tb_q[1] <= rb_q[1];
                    if (reg_addr < `SMC_PARAM_LIMIT)
                        {PARAM_GROUP, PARAM_INDEX} <= param_split(reg_addr);
                    if (rb_q[1] == `SMC_FN_WRITE)
                    begin
                        tb_q[2] <= rb_q[2];
                        tb_q[3] <= rb_q[3];
                        tb_q[4] <= rb_q[4];
                        tb_q[5] <= rb_q[5];
                        rlen_q  <= `SMC_LEN_WRITE_RSP;
                        if (rb_q[0] != `SMC_ADDR_BCAST_MUTE)
                            st_q <= S_TX;
                        if (reg_addr == `SMC_REG_FREQ)
                            FREQ_SETPOINT <= reg_val;
                        else if (reg_addr == `SMC_REG_CTRL)
                        begin
                            if (ctl_ok && reg_val[`SMC_CTL_RS] == `SMC_RS_STOP)
                                RUN_CMD <= 1'b0;
                            else if (ctl_ok && reg_val[`SMC_CTL_RS] == `SMC_RS_RUN)
                                RUN_CMD <= 1'b1;
                            if (ctl_ok && reg_val[`SMC_CTL_DIR] == `SMC_DIR_REV)
                                REVERSE_CMD <= 1'b1;
                            else if (ctl_ok && reg_val[`SMC_CTL_DIR] == `SMC_DIR_FWD)
                                REVERSE_CMD <= 1'b0;
                            else if (ctl_ok && reg_val[`SMC_CTL_DIR] == `SMC_DIR_TOGGLE)
                                REVERSE_CMD <= !REVERSE_CMD;
                        end
                        else if (reg_addr == `SMC_REG_EVENT)
                        begin
                            EXTERNAL_FAULT_INPUT <= (reg_val == `SMC_EVT_FAULT);
                            FAULT_RESET <= (reg_val == `SMC_EVT_RESET);
                        end
                        else if (reg_addr < `SMC_PARAM_LIMIT)
                        begin
                            PARAM_WDATA <= reg_val;
                            PARAM_WE    <= 1'b1;
                        end
                        else
                            st_q <= S_RX;
                    end
                    // Only one parameter per read is served; longer reads are dropped
                    else if (rb_q[1] == `SMC_FN_READ && reg_val == `SMC_READ_QTY
                             && reg_addr < `SMC_PARAM_LIMIT
                             && rb_q[0] != `SMC_ADDR_BCAST_MUTE)
                    begin
                        tb_q[2] <= `SMC_READ_BYTES;
                        rlen_q  <= `SMC_LEN_READ_RSP;
                        st_q    <= S_RDWAIT;
                    end
                end
                S_RDWAIT:
                begin
                    tb_q[3] <= PARAM_RDATA[15:8];
                    tb_q[4] <= PARAM_RDATA[7:0];
                    st_q    <= S_TX;
                end
                default:
                begin
                    if (push)
                    begin
                        if (tst_q == T_SOF)
                            tst_q <= T_DAT;
                        else if (tst_q == T_CR)
                            tst_q <= T_LF;
                        else if (tst_q == T_LF)
                            st_q <= S_RX;
                        else if (ASCII_MODE && !tnib_q)
                            tnib_q <= 1'b1;
                        else
                        begin
                            tnib_q <= 1'b0;
                            pos_q  <= pos_q + 3'h1;
                            if (pos_q == last_pos && ASCII_MODE)
                                tst_q <= T_CR;
                            else if (pos_q == last_pos)
                                st_q <= S_RX;
                        end
                    end
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// >>> rtl/smcmd_map.vh
// Constants of the serial drive command slave: frame characters, function codes,
// command register offsets, command fields and the line silence time.
// Assumes it is included by bare name from the rtl files of this block.
`ifndef SMCMD_MAP_VH
`define SMCMD_MAP_VH

// Ten milliseconds of line silence at 125 MHz
`define SMC_SILENCE_CYC    21'h1312d0
`define SMC_GAP_W          21

`define SMC_CH_COLON       8'h3a
`define SMC_CH_CR          8'h0d
`define SMC_CH_LF          8'h0a

`define SMC_ADDR_BCAST_MUTE 8'h00
`define SMC_ADDR_BCAST_ECHO 8'hff
`define SMC_FN_READ        8'h03
`define SMC_FN_WRITE       8'h06

`define SMC_REG_FREQ       16'h0fa0
`define SMC_REG_CTRL       16'h0fa1
`define SMC_REG_EVENT      16'h0fa2
`define SMC_PARAM_LIMIT    16'h03e8
`define SMC_PARAM_GROUP_W  4
`define SMC_PARAM_INDEX_W  7
`define SMC_GROUP_STRIDE   16'h0064

`define SMC_CTL_OVR        9
`define SMC_CTL_RS         1:0
`define SMC_CTL_DIR        5:4
`define SMC_RS_STOP        2'h1
`define SMC_RS_RUN         2'h2
`define SMC_DIR_REV        2'h1
`define SMC_DIR_FWD        2'h2
`define SMC_DIR_TOGGLE     2'h3
`define SMC_EVT_FAULT      16'h0001
`define SMC_EVT_RESET      16'h0002

`define SMC_CRC_PRESET     16'hffff
`define SMC_CRC_POLY       16'ha001
`define SMC_READ_QTY       16'h0001
`define SMC_READ_BYTES     8'h02

`define SMC_LEN_ASCII      4'h7
`define SMC_LEN_RTU        4'h8
`define SMC_LEN_READ_RSP   3'h5
`define SMC_LEN_WRITE_RSP  3'h6
`define SMC_FIFO_W         8
`define SMC_FIFO_D         8

`endif

// >>> rtl/smcmd_check.v
// Running frame check: Modbus CRC-16 and the two's complement longitudinal sum.
// Assumes byte steps arrive at most one per clock from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "smcmd_map.vh"

module smcmd_check
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clear,
    input  wire        step,
    input  wire [7:0]  data,
    output wire [15:0] crc,
    output wire [7:0]  lrc
);
    reg  [15:0] crc_q;
    reg  [7:0]  sum_q;
    wire [15:0] crc_base;
    wire [7:0]  sum_base;

    function [15:0] crc_byte;
        input [15:0] acc;
        input [7:0]  b;
        integer      i;
        reg   [15:0] a;
        begin
            a = acc ^ {8'h00, b};
            for (i = 0; i < 8; i = i + 1)
            begin
                if (a[0])
                    a = {1'b0, a[15:1]} ^ `SMC_CRC_POLY;
                else
                    a = {1'b0, a[15:1]};
            end
            crc_byte = a;
        end
    endfunction

    assign crc_base = clear ? `SMC_CRC_PRESET : crc_q;
    assign sum_base = clear ? 8'h00 : sum_q;
    assign crc = crc_q;
    assign lrc = 8'h00 - sum_q;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            crc_q <= `SMC_CRC_PRESET;
            sum_q <= 8'h00;
        end
        else
        begin
            crc_q <= step ? crc_byte(crc_base, data) : crc_base;
            sum_q <= step ? sum_base + data : sum_base;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/smcmd_fifo.v
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/100ps
`default_nettype none
`include "smcmd_map.vh"

module smcmd_fifo
#(
    parameter WIDTH = `SMC_FIFO_W,
    parameter DEPTH = `SMC_FIFO_D,
    parameter AW    = 3
)
(
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0]    wr_q;
    reg  [AW-1:0]    rd_q;
    reg  [AW:0]      cnt_q;
    wire             push;
    wire             pop;

    assign in_ready  = (cnt_q != DEPTH);
    assign out_valid = (cnt_q != 0);
    assign out_data  = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    always @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

`default_nettype wire

// >>> verif/smcmd_asserts.sv
// Checker for the serial drive command slave: reply timing and command pulses.
// Assumes it is bound to smcmd_top and that everything runs on CLOCK.
`timescale 1ns/100ps
`default_nettype none
module smcmd_asserts
#(
    parameter [20:0] SILENCE_CYC = 21'd50
)
(
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic        ASCII_MODE,
    input wire logic        RX_VALID,
    input wire logic        TX_VALID,
    input wire logic [7:0]  TX_CHAR,
    input wire logic        TX_READY,
    input wire logic [15:0] FREQ_SETPOINT,
    input wire logic [3:0]  PARAM_GROUP,
    input wire logic [6:0]  PARAM_INDEX,
    input wire logic        PARAM_WE,
    input wire logic        EXTERNAL_FAULT_INPUT,
    input wire logic        FAULT_RESET
);
    logic [20:0] quiet_q;
    logic [20:0] quiet_d;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Saturates so a long idle line never wraps back to a short count
    always_comb quiet_d = RX_VALID ? 21'd0 : (quiet_q == SILENCE_CYC ? quiet_q : quiet_q + 21'd1);
    always_ff @(posedge CLOCK) quiet_q <= !RST_N ? SILENCE_CYC : quiet_d;
    sequence s_tx_stall;
        TX_VALID && !TX_READY;
    endsequence
    sequence s_rtu_reply;
        $rose(TX_VALID) && !ASCII_MODE;
    endsequence
    a_tx_char_held: assert property (s_tx_stall |=> TX_VALID && $stable(TX_CHAR))
        else $error("response character changed while stalled");
    a_reply_after_silence: assert property (s_rtu_reply |-> quiet_q >= SILENCE_CYC)
        else $error("reply started before line silence");
    a_write_pulse_single: assert property (PARAM_WE |=> !PARAM_WE)
        else $error("parameter write pulse longer than one cycle");
    a_fault_pulse_single: assert property (EXTERNAL_FAULT_INPUT |=> !EXTERNAL_FAULT_INPUT)
        else $error("fault pulse longer than one cycle");
    a_freset_pulse_single: assert property (FAULT_RESET |=> !FAULT_RESET)
        else $error("fault reset pulse longer than one cycle");
    a_event_one_kind: assert property (!(EXTERNAL_FAULT_INPUT && FAULT_RESET))
        else $error("fault and fault reset together");
    a_param_index_range: assert property (PARAM_INDEX < 7'd100 && PARAM_GROUP < 4'd10)
        else $error("parameter group or index out of range");
    a_reset_outputs_clear: assert property ($rose(RST_N) |-> !TX_VALID && FREQ_SETPOINT == 16'h0000)
        else $error("outputs not clear after reset");
endmodule
bind smcmd_top smcmd_asserts #(.SILENCE_CYC(SILENCE_CYC)) smcmd_asserts_inst (.CLOCK(CLOCK),
    .RST_N(RST_N), .ASCII_MODE(ASCII_MODE), .RX_VALID(RX_VALID), .TX_VALID(TX_VALID),
    .TX_CHAR(TX_CHAR), .TX_READY(TX_READY), .FREQ_SETPOINT(FREQ_SETPOINT),
    .PARAM_GROUP(PARAM_GROUP), .PARAM_INDEX(PARAM_INDEX), .PARAM_WE(PARAM_WE),
    .EXTERNAL_FAULT_INPUT(EXTERNAL_FAULT_INPUT), .FAULT_RESET(FAULT_RESET));
`default_nettype wire

// >>> verif/smcmd_master.sv
// Bus master model: frames requests with their check and collects replies.
// Assumes the slave's character ports on one clock; slow stalls every other cycle.
`timescale 1ns/100ps
`default_nettype none
module smcmd_master
#(
    parameter int SIL = 50
)
(
    input  wire logic       clk,
    input  wire logic       ascii,
    input  wire logic       slow,
    output var logic        rx_valid,
    output var logic [7:0]  rx_char,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_char,
    output var logic        tx_ready
);
    logic [7:0] frm[$];
    logic [7:0] rsp[$];
    logic       corrupt = 1'b0;
    initial rx_valid = 1'b0;
    initial rx_char = 8'h00;
    initial tx_ready = 1'b1;
    function automatic logic [15:0] crc16(input logic [7:0] m[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (m[i])
        begin
            c = c ^ {8'h00, m[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'ha ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction
    task automatic build(input logic [7:0] m[$]);
        logic [7:0]  s;
        logic [15:0] c;
        s = 8'h00;
        c = crc16(m);
        foreach (m[i]) s = s + m[i];
        s = 8'h00 - s;
        if (ascii)
        begin
            m.push_back(s);
            frm = {8'h3a};
            foreach (m[i]) frm = {frm, hx(m[i][7:4]), hx(m[i][3:0])};
            frm = {frm, 8'h0d, 8'h0a};
        end
        else
            frm = {m, c[7:0] ^ {7'h00, corrupt}, c[15:8]};
    endtask
    task automatic send(input logic [7:0] m[$]);
        build(m);
        rsp = {};
        foreach (frm[i])
        begin
            @(posedge clk) #1;
            rx_valid = 1'b1;
            rx_char = frm[i];
            @(posedge clk) #1;
            rx_valid = 1'b0;
            rx_char = ~rx_char;
        end
        if (!ascii) repeat (SIL + 4) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        if (tx_valid && tx_ready)
            rsp.push_back(tx_char);
        #1 tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule
`default_nettype wire

// >>> verif/smcmd_top_tb.sv
// Testbench for the serial drive command slave: RTU and ASCII exchanges.
// Assumes the master model and a parameter store made from the address.
`timescale 1ns/100ps
`default_nettype none
module smcmd_top_tb;
    localparam int SIL = 50;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ascii = 1'b0;
    logic        panel = 1'b0;
    logic        slow = 1'b1;
    logic        rx_valid, tx_valid, tx_ready, run, rev, fault, freset, we;
    logic [7:0]  rx_char, tx_char;
    logic [15:0] freq, wdata, rdata;
    logic [3:0]  grp;
    logic [6:0]  idx;
    logic [2:0]  seen = 3'b000;
    logic        seen_clr = 1'b0;
    logic [15:0] codes[8] = '{16'h0002, 16'h0001, 16'h0201, 16'h0010,
                              16'h0210, 16'h0020, 16'h0030, 16'h0202};
    logic [7:0]  lit = 8'b10011110;
    logic [7:0]  er = 8'b10000011;
    logic [7:0]  ev = 8'b11010000;
    int          bad_count = 0;
    int          checked = 0;
    int          cyc = 0;
    always #4 clk = ~clk;
    assign rdata = grp * 16'd100 + {9'h000, idx} + 16'h1000;
    always @(posedge clk) seen <= seen_clr ? 3'b000 : seen | {we, freset, fault};
    smcmd_top #(.SILENCE_CYC(21'd50)) smcmd_top_inst (.CLOCK(clk), .RST_N(rst_n),
        .ASCII_MODE(ascii), .SLAVE_ADDR(8'h01), .OPERATOR_PANEL_LIT(panel), .RX_VALID(rx_valid),
        .RX_CHAR(rx_char), .TX_VALID(tx_valid), .TX_CHAR(tx_char), .TX_READY(tx_ready),
        .FREQ_SETPOINT(freq), .RUN_CMD(run), .REVERSE_CMD(rev), .EXTERNAL_FAULT_INPUT(fault),
        .FAULT_RESET(freset), .PARAM_GROUP(grp), .PARAM_INDEX(idx), .PARAM_WDATA(wdata),
        .PARAM_WE(we), .PARAM_RDATA(rdata));
    smcmd_master #(.SIL(SIL)) smcmd_master_inst (.clk(clk), .ascii(ascii), .slow(slow),
        .rx_valid(rx_valid), .rx_char(rx_char), .tx_valid(tx_valid), .tx_char(tx_char),
        .tx_ready(tx_ready));
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic exch(input logic [7:0] q[$], input int n);
        #1 seen_clr = 1'b1;
        @(posedge clk) #1 seen_clr = 1'b0;
        smcmd_master_inst.send(q);
        for (int i = 0; i < 400 && smcmd_master_inst.rsp.size() < n; i++) @(posedge clk);
        repeat (SIL + 10) @(posedge clk);
        check(smcmd_master_inst.rsp.size() == n, "reply length");
        $display("test done at %0t", $time);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] r, input logic [15:0] d,
                      input bit rep);
        exch('{a, 8'h06, r[15:8], r[7:0], d[15:8], d[7:0]}, rep ? (ascii ? 17 : 8) : 0);
        if (rep)
            check(smcmd_master_inst.rsp == smcmd_master_inst.frm, "echo");
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        wr(8'h01, 16'h0064, 16'h1770, 1'b1);
        check(smcmd_master_inst.frm[6] === 8'hc6 && smcmd_master_inst.frm[7] === 8'h01, "crc");
        check(seen[2] === 1'b1 && grp === 4'h1 && idx === 7'h00 && wdata === 16'h1770, "wr");
        exch('{8'h01, 8'h03, 8'h02, 8'h08, 8'h00, 8'h01}, 7);
        smcmd_master_inst.build('{8'h01, 8'h03, 8'h02, 8'h12, 8'h08});
        check(smcmd_master_inst.rsp == smcmd_master_inst.frm, "read reply");
        wr(8'h01, 16'h0fa0, 16'h1770, 1'b1);
        check(freq === 16'h1770, "frequency");
        smcmd_master_inst.corrupt = 1'b1;
        wr(8'h01, 16'h0fa0, 16'h0001, 1'b0);
        smcmd_master_inst.corrupt = 1'b0;
        wr(8'h02, 16'h0fa0, 16'h0001, 1'b0);
        check(freq === 16'h1770, "bad check or foreign address executed");
        wr(8'h00, 16'h0fa0, 16'h0bb8, 1'b0);
        check(freq === 16'h0bb8, "broadcast");
        wr(8'hff, 16'h0fa0, 16'h1000, 1'b1);
        #1 slow = 1'b0;
        ascii = 1'b1;
        wr(8'h01, 16'h0064, 16'h1770, 1'b1);
        check(smcmd_master_inst.frm[13] === 8'h30 && smcmd_master_inst.frm[14] === 8'h45, "lrc");
        for (int i = 0; i < 8; i++)
        begin
            #1 panel = lit[i];
            wr(8'h01, 16'h0fa1, codes[i], 1'b1);
            check(run === er[i] && rev === ev[i], "control");
        end
        wr(8'h01, 16'h0fa2, 16'h0001, 1'b1);
        check(seen[0] === 1'b1 && seen[1] === 1'b0, "fault");
        wr(8'h01, 16'h0fa2, 16'h0002, 1'b1);
        check(seen[1] === 1'b1 && seen[0] === 1'b0, "fault reset");
        finish_test();
    end
endmodule
`default_nettype wire
